// ---- design/ntc_pkg.sv ----
/*
  Package for the nonvolatile table access control block: register offsets,
  field positions, reset values, unlock pattern, target and operation codes.
  Assumes a byte-wide register port with one-cycle read latency.
*/
package ntc_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int PTR_W = 22;
  localparam int PTR_LOW_W = 21;
  localparam int BLK_W = 5;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_UNLOCK = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_LATCH = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_PTR_LOW = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_PTR_HIGH = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_PTR_UPPER = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_IRQ7 = 3'h6;

  // Control register fields
  localparam int CTL_REGION_HI = 7;
  localparam int CTL_REGION_LO = 6;
  localparam int CTL_ERASE = 4;
  localparam int CTL_FAULT = 3;
  localparam int CTL_PERMIT = 2;
  localparam int CTL_START = 1;

  // Flag register field
  localparam int IRQ7_DONE = 5;

  // Region select codes
  localparam logic [1:0] REGION_EEPROM = 2'h0;
  localparam logic [1:0] REGION_FLASH = 2'h2;

  // Two-write unlock pattern
  localparam logic [DATA_W-1:0] UNLOCK_FIRST = 8'h55;
  localparam logic [DATA_W-1:0] UNLOCK_SECOND = 8'haa;

  // Pointer update modes of the table instructions
  localparam logic [1:0] UPD_NONE = 2'h0;
  localparam logic [1:0] UPD_POST_INC = 2'h1;
  localparam logic [1:0] UPD_POST_DEC = 2'h2;
  localparam logic [1:0] UPD_PRE_INC = 2'h3;

  // Array targets and operations
  localparam logic [1:0] TGT_EEPROM = 2'h0;
  localparam logic [1:0] TGT_FLASH = 2'h1;
  localparam logic [1:0] TGT_CONFIG = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_ERASE = 2'h1;
  localparam logic [1:0] OP_ERASE_WRITE = 2'h2;

  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;

  typedef enum logic [1:0] {
    UNL_IDLE,
    UNL_HALF,
    UNL_ARMED
  } ntc_unlock_e;

endpackage

// ---- design/ntc_table_ctl.sv ----
/*
  Nonvolatile table access control: control/unlock/flag registers, table
  latch and 22-bit table pointer, table read/write sequencing, and the start
  and completion handshake toward the flash and EEPROM arrays.
  Assumes the arrays and the core run on i_clk; i_nv_done is a one-cycle
  pulse and i_fetch_data is valid in the cycle in which o_fetch_req stands.
*/
// Summary of operation
// - Region 00 targets data EEPROM
// - Region 10 targets program flash
// - Region x1 targets ID/configuration space
// - Unlock location stores nothing, reads zero
// - Erase select turns flash start into erase
// - Program only with permit; permit reset clear
// - Fault set on start, cleared on success
// - EEPROM start erases+writes; flash start writes
// - Software can only set start bit
// - Hardware clears start when operation ends
// - Completion flag sticky until software clears
// - Eight-bit table latch holds moving bytes
// - Upper, high, low bytes form 22-bit pointer
// - Low 21 bits address program memory
// - Top pointer bit selects ID/config space
// - Automatic updates touch low 21 bits only
// - Table read fetches byte into latch
// - Table write fills holding register by offset
// - Flash commit uses upper pointer bits only
`timescale 1ns/10ps
module ntc_table_ctl (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [ntc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ntc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [ntc_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_tbl_rd,
  input wire logic i_tbl_wr,
  input wire logic [1:0] i_tbl_mode,
  output logic o_fetch_req,
  output logic [ntc_pkg::PTR_W-1:0] o_fetch_addr,
  input wire logic [ntc_pkg::DATA_W-1:0] i_fetch_data,
  output logic o_hold_we,
  output logic [ntc_pkg::BLK_W-1:0] o_hold_idx,
  output logic [ntc_pkg::DATA_W-1:0] o_hold_data,
  output logic o_nv_start,
  output logic [1:0] o_nv_target,
  output logic [1:0] o_nv_op,
  output logic [ntc_pkg::PTR_W-1:0] o_nv_addr,
  output logic [ntc_pkg::DATA_W-1:0] o_nv_data,
  input wire logic i_nv_done,
  input wire logic i_nv_ok,
  output logic o_busy,
  output logic o_done_flag
);
  import ntc_pkg::*;

  typedef struct packed {
    logic [1:0] region;
    logic erase_sel;
    logic fault;
    logic permit;
    logic start;
    logic done_flag;
    ntc_unlock_e unlock;
    logic [DATA_W-1:0] latch;
    logic [PTR_W-1:0] ptr;
    logic fetch_pend;
    logic fetch_req;
    logic [PTR_W-1:0] fetch_addr;
    logic hold_we;
    logic [BLK_W-1:0] hold_idx;
    logic [DATA_W-1:0] hold_data;
    logic nv_start;
    logic [1:0] nv_target;
    logic [1:0] nv_op;
    logic [PTR_W-1:0] nv_addr;
    logic [DATA_W-1:0] nv_data;
    logic [DATA_W-1:0] rdata;
  } ntc_state_s;

  logic rst_meta_q;
  logic rst_sync_q;
  ntc_state_s s_q;
  ntc_state_s s_d;

  // Reset is released through two flops so every state flop leaves reset together
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  logic [PTR_LOW_W-1:0] low_inc;
  logic [PTR_LOW_W-1:0] low_dec;
  logic [PTR_W-1:0] ptr_inc;
  logic [PTR_W-1:0] ptr_dec;
  logic [1:0] target;
  logic [1:0] op;

  always_comb begin
    low_inc = s_q.ptr[PTR_LOW_W-1:0] + 21'h000001;
    low_dec = s_q.ptr[PTR_LOW_W-1:0] - 21'h000001;
    ptr_inc = {s_q.ptr[PTR_W-1], low_inc};
    ptr_dec = {s_q.ptr[PTR_W-1], low_dec};
  end

  // Region decode and the operation a start launches
  always_comb begin
    if (s_q.region[0]) begin
      target = TGT_CONFIG;
    end else if (s_q.region == REGION_FLASH) begin
      target = TGT_FLASH;
    end else begin
      target = TGT_EEPROM;
    end
    case (target)
      TGT_EEPROM: op = OP_ERASE_WRITE;
      TGT_FLASH: op = s_q.erase_sel ? OP_ERASE : OP_WRITE;
      default: op = OP_WRITE;
    endcase
  end

  logic wr_ctrl;
  logic start_req;
  logic start_ok;
  logic finish;

  always_comb begin
    wr_ctrl = i_wr && (i_addr == OFS_CTRL);
    start_req = wr_ctrl && i_wdata[CTL_START] && !s_q.start;
    // A start without permission or without the unlock pattern is dropped
    start_ok = start_req && s_q.permit && (s_q.unlock == UNL_ARMED);
    finish = s_q.start && i_nv_done;
  end

  always_comb begin
    s_d = s_q;
    s_d.fetch_req = 1'b0;
    s_d.fetch_pend = 1'b0;
    s_d.hold_we = 1'b0;
    s_d.nv_start = 1'b0;
    s_d.rdata = RST_BYTE;

    // Any register write other than the pattern step disarms the unlock
    if (i_wr) begin
      if (i_addr == OFS_UNLOCK) begin
        if (i_wdata == UNLOCK_FIRST) begin
          s_d.unlock = UNL_HALF;
        end else if (i_wdata == UNLOCK_SECOND && s_q.unlock == UNL_HALF) begin
          s_d.unlock = UNL_ARMED;
        end else begin
          s_d.unlock = UNL_IDLE;
        end
      end else begin
        s_d.unlock = UNL_IDLE;
      end
    end

    if (wr_ctrl) begin
      s_d.permit = i_wdata[CTL_PERMIT];
      if (!s_q.start) begin
        s_d.region = i_wdata[CTL_REGION_HI:CTL_REGION_LO];
        s_d.erase_sel = i_wdata[CTL_ERASE];
      end
    end

    if (start_ok) begin
      s_d.start = 1'b1;
      s_d.fault = 1'b1;
      s_d.nv_start = 1'b1;
      s_d.nv_target = target;
      s_d.nv_op = op;
      s_d.nv_data = s_q.latch;
      if (target == TGT_FLASH) begin
        s_d.nv_addr = {s_q.ptr[PTR_W-1:BLK_W], {BLK_W{1'b0}}};
      end else begin
        s_d.nv_addr = s_q.ptr;
      end
    end

    if (finish) begin
      s_d.start = 1'b0;
      if (i_nv_ok) begin
        s_d.fault = 1'b0;
      end
    end

    // Pointer and latch writes are frozen during a programming cycle
    if (i_wr && !s_q.start) begin
      case (i_addr)
        OFS_LATCH: s_d.latch = i_wdata;
        OFS_PTR_LOW: s_d.ptr[7:0] = i_wdata;
        OFS_PTR_HIGH: s_d.ptr[15:8] = i_wdata;
        OFS_PTR_UPPER: s_d.ptr[PTR_W-1:16] = i_wdata[PTR_W-17:0];
        default: s_d.ptr = s_d.ptr;
      endcase
    end

    // Software clears the flag by writing zero; completion wins the tie
    if (i_wr && i_addr == OFS_IRQ7) begin
      s_d.done_flag = s_q.done_flag & i_wdata[IRQ7_DONE];
    end
    if (finish) begin
      s_d.done_flag = 1'b1;
    end

    // Table instructions; ignored while the arrays are busy
    if (!s_q.start && (i_tbl_rd || i_tbl_wr)) begin
      case (i_tbl_mode)
        UPD_POST_INC: s_d.ptr = ptr_inc;
        UPD_POST_DEC: s_d.ptr = ptr_dec;
        UPD_PRE_INC: s_d.ptr = ptr_inc;
        default: s_d.ptr = s_q.ptr;
      endcase
      if (i_tbl_rd) begin
        s_d.fetch_req = 1'b1;
        s_d.fetch_pend = 1'b1;
        // All 22 bits go out, so the top bit reaches the config space
        s_d.fetch_addr = (i_tbl_mode == UPD_PRE_INC) ? ptr_inc : s_q.ptr;
      end else begin
        s_d.hold_we = 1'b1;
        s_d.hold_data = s_q.latch;
        if (i_tbl_mode == UPD_PRE_INC) begin
          s_d.hold_idx = ptr_inc[BLK_W-1:0];
        end else begin
          s_d.hold_idx = s_q.ptr[BLK_W-1:0];
        end
      end
    end

    // Fetched byte lands in the latch one cycle after the request
    if (s_q.fetch_pend) begin
      s_d.latch = i_fetch_data;
    end

    if (i_rd) begin
      case (i_addr)
        OFS_CTRL: begin
          s_d.rdata = {s_q.region, 1'b0, s_q.erase_sel, s_q.fault, s_q.permit, s_q.start, 1'b0};
        end
        OFS_UNLOCK: s_d.rdata = RST_BYTE;
        OFS_LATCH: s_d.rdata = s_q.latch;
        OFS_PTR_LOW: s_d.rdata = s_q.ptr[7:0];
        OFS_PTR_HIGH: s_d.rdata = s_q.ptr[15:8];
        OFS_PTR_UPPER: s_d.rdata = {2'h0, s_q.ptr[PTR_W-1:16]};
        OFS_IRQ7: s_d.rdata = {2'h0, s_q.done_flag, 5'h00};
        default: s_d.rdata = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    o_rdata = s_q.rdata;
    o_fetch_req = s_q.fetch_req;
    o_fetch_addr = s_q.fetch_addr;
    o_hold_we = s_q.hold_we;
    o_hold_idx = s_q.hold_idx;
    o_hold_data = s_q.hold_data;
    o_nv_start = s_q.nv_start;
    o_nv_target = s_q.nv_target;
    o_nv_op = s_q.nv_op;
    o_nv_addr = s_q.nv_addr;
    o_nv_data = s_q.nv_data;
    o_busy = s_q.start;
    o_done_flag = s_q.done_flag;
  end

endmodule

// ---- bench/ntc_table_ctl_asserts.sv ----
/* Port checker for the table access control block.
   Bound from the bench top; sees only the top ports, one clock domain. */
`timescale 1ns/10ps
module ntc_table_ctl_asserts
  import ntc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [ntc_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [ntc_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_tbl_rd,
  input wire logic i_tbl_wr,
  input wire logic o_fetch_req,
  input wire logic o_hold_we,
  input wire logic o_nv_start,
  input wire logic [1:0] o_nv_target,
  input wire logic [1:0] o_nv_op,
  input wire logic [ntc_pkg::PTR_W-1:0] o_nv_addr,
  input wire logic i_nv_done,
  input wire logic o_busy,
  input wire logic o_done_flag
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_unl; i_rd && i_addr == OFS_UNLOCK |=> o_rdata == 8'h00; endproperty
  a_unl: assert property (p_unl) else $error("unlock read not zero");
  property p_ee; o_nv_start && o_nv_target == TGT_EEPROM |-> o_nv_op == OP_ERASE_WRITE; endproperty
  a_ee: assert property (p_ee) else $error("eeprom op wrong");
  property p_fl; o_nv_start && o_nv_target == TGT_FLASH |-> o_nv_addr[4:0] == 5'h00; endproperty
  a_fl: assert property (p_fl) else $error("flash block offset not zero");
  property p_rise; $rose(o_busy) |-> o_nv_start; endproperty
  a_rise: assert property (p_rise) else $error("busy without start");
  property p_hold; o_busy && !i_nv_done |=> o_busy; endproperty
  a_hold: assert property (p_hold) else $error("busy dropped early");
  property p_end; o_busy && i_nv_done |=> !o_busy && o_done_flag; endproperty
  a_end: assert property (p_end) else $error("completion not seen");
  property p_sticky; o_done_flag && !(i_wr && i_addr == OFS_IRQ7) |=> o_done_flag; endproperty
  a_sticky: assert property (p_sticky) else $error("done flag lost");
  property p_fetch; i_tbl_rd && !o_busy |=> o_fetch_req; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch missing");
  property p_twr; i_tbl_wr && !o_busy |=> o_hold_we; endproperty
  a_twr: assert property (p_twr) else $error("holding write missing");
  property p_frz; o_busy && (i_tbl_rd || i_tbl_wr) |=> !o_fetch_req && !o_hold_we; endproperty
  a_frz: assert property (p_frz) else $error("table op while busy");
  c_erase: cover property (o_nv_start && o_nv_op == OP_ERASE);
  c_end: cover property (o_busy && i_nv_done);
  c_twr: cover property (o_hold_we);
endmodule

// ---- bench/ntc_array_model.sv ----
/* Behavioural flash and EEPROM arrays facing the control block.
   Same clock; answers a start after a short or long delay. */
`timescale 1ns/10ps
module ntc_array_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_fetch_req,
  input wire logic [21:0] i_fetch_addr,
  input wire logic i_slow,
  input wire logic i_fail,
  output logic o_done,
  output logic o_ok,
  output logic [7:0] o_fetch_data
);
  int cnt;
  logic [7:0] junk_q;
  // The byte answers in the request cycle; between fetches a toggling byte stands, so stale data never passes
  assign o_fetch_data = i_fetch_req ?
    (i_fetch_addr[7:0] ^ i_fetch_addr[15:8] ^ {2'h0, i_fetch_addr[21:16]}) : junk_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 0;
      o_done <= 1'b0;
      o_ok <= 1'b0;
      junk_q <= 8'h00;
    end else begin
      junk_q <= ~junk_q;
      cnt <= i_start ? (i_slow ? 30 : 12) : (cnt > 0 ? cnt - 1 : 0);
      o_done <= (cnt == 1);
      o_ok <= (cnt == 1) ? ~i_fail : ~o_ok;
    end
  end
endmodule

// ---- bench/test_nvm_table_access_control.sv ----
/* Self-checking bench for the table access control block.
   Drives register port and table ops; the array model answers. */
`timescale 1ns/10ps
module test_nvm_table_access_control;
  import ntc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, trd = 1'b0, twr = 1'b0, slow = 1'b0, fail = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, fdat, hdata, nvdata;
  logic [1:0] mode = 2'h0, tgt, op;
  logic [21:0] faddr, nvaddr;
  logic [4:0] hidx;
  logic freq, hwe, start, done, ok, busy, dflag;
  int err_count = 0, n_checks = 0, cyc = 0;
  ntc_table_ctl dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_tbl_rd(trd), .i_tbl_wr(twr), .i_tbl_mode(mode), .o_fetch_req(freq),
    .o_fetch_addr(faddr), .i_fetch_data(fdat), .o_hold_we(hwe), .o_hold_idx(hidx), .o_hold_data(hdata),
    .o_nv_start(start), .o_nv_target(tgt), .o_nv_op(op), .o_nv_addr(nvaddr), .o_nv_data(nvdata),
    .i_nv_done(done), .i_nv_ok(ok), .o_busy(busy), .o_done_flag(dflag));
  ntc_array_model u_arr (.i_clk(clk), .i_rst_n(rst_n), .i_start(start), .i_fetch_req(freq),
    .i_fetch_addr(faddr), .i_slow(slow), .i_fail(fail), .o_done(done), .o_ok(ok), .o_fetch_data(fdat));
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic tbl(input logic r, input logic [1:0] m);
    @(posedge clk);
    trd <= r;
    twr <= ~r;
    mode <= m;
    @(posedge clk);
    trd <= 1'b0;
    twr <= 1'b0;
    @(negedge clk);
  endtask
  function automatic logic [3:0] exp_cmd(input logic [1:0] r, input logic e);
    if (r[0]) return {TGT_CONFIG, OP_WRITE};
    if (r == REGION_FLASH) return {TGT_FLASH, e ? OP_ERASE : OP_WRITE};
    return {TGT_EEPROM, OP_ERASE_WRITE};
  endfunction
  function automatic logic [21:0] nxt(input logic [21:0] q, input logic [1:0] m);
    case (m)
      UPD_POST_INC, UPD_PRE_INC: return {q[21], q[20:0] + 21'h000001};
      UPD_POST_DEC: return {q[21], q[20:0] - 21'h000001};
      default: return q;
    endcase
  endfunction
  function automatic logic [7:0] fx(input logic [21:0] q);
    return q[7:0] ^ q[15:8] ^ {2'h0, q[21:16]};
  endfunction
  initial begin
    logic [7:0] d, c;
    logic [3:0] x;
    logic [1:0] m;
    logic [21:0] p, a;
    void'($urandom(32875));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rreg(OFS_CTRL, d);
    chk("ctrl reset", d, 8'h00);
    rreg(OFS_UNLOCK, d);
    chk("unlock read", d, 8'h00);
    wreg(OFS_UNLOCK, UNLOCK_FIRST);
    wreg(OFS_UNLOCK, UNLOCK_SECOND);
    wreg(OFS_CTRL, 8'h82);
    @(negedge clk);
    chk("start no permit", busy, 1'b0);
    wreg(OFS_CTRL, 8'h84);
    wreg(OFS_CTRL, 8'h86);
    @(negedge clk);
    chk("start no unlock", busy, 1'b0);
    for (int k = 0; k < 8; k++) begin
      c = {k[2:1], 1'b0, k[0], 4'h4};
      slow <= k[1];
      fail <= (k == 5);
      x = exp_cmd(c[7:6], c[4]);
      a = 22'($urandom);
      wreg(OFS_CTRL, c);
      wreg(OFS_LATCH, a[7:0]);
      wreg(OFS_PTR_LOW, a[7:0]);
      wreg(OFS_UNLOCK, UNLOCK_FIRST);
      wreg(OFS_UNLOCK, UNLOCK_SECOND);
      wreg(OFS_CTRL, c | 8'h02);
      @(negedge clk);
      chk("start", start, 1'b1);
      chk("target", tgt, x[3:2]);
      chk("operation", op, x[1:0]);
      chk("nv addr", nvaddr, (x[3:2] == TGT_FLASH) ? {14'h0000, a[7:5], 5'h00} : {14'h0000, a[7:0]});
      chk("nv data", nvdata, a[7:0]);
      rreg(OFS_CTRL, d);
      chk("ctrl busy", d, c | 8'h0a);
      wreg(OFS_CTRL, c);
      wreg(OFS_LATCH, ~a[7:0]);
      rreg(OFS_LATCH, d);
      chk("latch frozen", d, a[7:0]);
      tbl(1'b1, UPD_POST_INC);
      chk("still busy", busy, 1'b1);
      chk("no fetch busy", freq, 1'b0);
      for (int i = 0; i < 40 && busy; i++) @(negedge clk);
      chk("busy end", busy, 1'b0);
      chk("done flag", dflag, 1'b1);
      rreg(OFS_CTRL, d);
      chk("ctrl end", d, c | {4'h0, k == 5, 3'h0});
      wreg(OFS_IRQ7, 8'hff);
      @(negedge clk);
      chk("flag kept", dflag, 1'b1);
      wreg(OFS_IRQ7, 8'h00);
      @(negedge clk);
      chk("flag clear", dflag, 1'b0);
    end
    p = 22'h3fffff;
    for (int k = 0; k < 12; k++) begin
      m = (k == 0) ? UPD_POST_INC : 2'($urandom);
      wreg(OFS_PTR_LOW, p[7:0]);
      wreg(OFS_PTR_HIGH, p[15:8]);
      wreg(OFS_PTR_UPPER, {2'h0, p[21:16]});
      a = (m == UPD_PRE_INC) ? nxt(p, m) : p;
      tbl(1'b1, m);
      chk("fetch", {freq, faddr}, {1'b1, a});
      p = nxt(p, m);
      rreg(OFS_LATCH, d);
      chk("latch", d, fx(a));
      rreg(OFS_PTR_UPPER, d);
      chk("ptr upper", d, {2'h0, p[21:16]});
      c = fx(a);
      a = (m == UPD_PRE_INC) ? nxt(p, m) : p;
      tbl(1'b0, m);
      chk("hold", {hwe, hidx, hdata}, {1'b1, a[4:0], c});
      p = 22'($urandom);
    end
    finish_test();
  end
endmodule
bind ntc_table_ctl ntc_table_ctl_asserts u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tbl_rd(i_tbl_rd), .i_tbl_wr(i_tbl_wr),
  .o_fetch_req(o_fetch_req), .o_hold_we(o_hold_we), .o_nv_start(o_nv_start), .o_nv_target(o_nv_target),
  .o_nv_op(o_nv_op), .o_nv_addr(o_nv_addr), .i_nv_done(i_nv_done), .o_busy(o_busy), .o_done_flag(o_done_flag));
